// ===== logic/irs_sequencer.sv
// integrator reset sequencer: lockout, calibration, reset and watchdog
// What this block does
// - lockout forces outputs minimum, ignores inputs
// - leave lockout at threshold plus hysteresis
// - calibrate after lockout, outputs minimum
// - enable inputs after calibration; first reset
// - measure after each reset, then alternate
// - reverse current keeps measure output minimum
// - select tied high: reset follows inputs
// - select resistor: reset condition fires one-shot
// - one-shot holds reset for programmed time, minimum MIN_RESET_CYCLES (15 cycles)
// - fault when measurement exceeds watchdog limit
// - calibrate on every exit from lockout, including after each supply dip below threshold
// - fault output active low
// - reset true when first two inputs differ
`timescale 1ns/1ps
module irs_sequencer
	import irs_pkg::*;
#(
	parameter int unsigned CAL_LEN = CAL_CYCLES,
	parameter int unsigned WD_LEN = WATCHDOG_LIMIT_CYCLES
) (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic supply_above_lockout_threshold,
	input wire logic supply_above_lockout_hysteresis,
	input wire irs_pkg::irs_link_in_t link_in,
	input wire logic reset_follow_select,
	input wire logic [11:0] oneshot_steps,
	output irs_pkg::irs_meas_out_t meas_out,
	output logic fault_b,
	output logic calibrating,
	output logic [1:0] seq_state
);
	import irs_pkg::*;

	irs_link_in_t link_sync;
	logic lock_high_s;
	logic lock_hyst_s;
	logic follow_s;
	irs_state_t state;
	irs_state_t next_state;
	logic [CNT_W-1:0] count;
	logic [CNT_W-1:0] next_count;
	logic in_reset_prev;
	logic oneshot_busy;

	irs_sync2 #(.WIDTH(6)) u_sync_link (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.async_in(link_in),
		.sync_out(link_sync)
	);

	irs_sync2 #(.WIDTH(3)) u_sync_cfg (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.async_in({supply_above_lockout_threshold, supply_above_lockout_hysteresis,
			reset_follow_select}),
		.sync_out({lock_high_s, lock_hyst_s, follow_s})
	);

	// reset condition is xor of first two inputs
	wire logic reset_cond = link_sync.reset_timing_inputs[0] ^ link_sync.reset_timing_inputs[1];
	wire logic inputs_enabled = (state == IRS_ARMED) || (state == IRS_RUN);
	wire logic trigger = inputs_enabled && reset_cond;

	irs_oneshot u_oneshot (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.trigger(trigger && !follow_s),
		.duration(oneshot_steps),
		.busy(oneshot_busy)
	);

	// follow mode: reset exactly while condition holds
	wire logic in_reset = follow_s ? trigger : oneshot_busy;
	// reset end restarts the watchdog count
	wire logic reset_end = in_reset_prev && !in_reset;
	wire logic forward = link_sync.current_entry && !link_sync.current_exit;
	wire logic measuring = (state == IRS_RUN) && !in_reset;
	wire logic wd_expired = measuring && (count >= CNT_W'(WD_LEN - 1));

	always_comb
	begin
		next_state = state;
		next_count = count;
		case (state)
			IRS_LOCKOUT:
			begin
				next_count = CNT_RESET;
				if (lock_high_s && lock_hyst_s)
				begin
					next_state = IRS_CALIBRATE;
				end
			end
			IRS_CALIBRATE:
			begin
				next_count = count + CNT_W'(1);
				if (count >= CNT_W'(CAL_LEN - 1))
				begin
					next_state = IRS_ARMED;
					next_count = CNT_RESET;
				end
			end
			IRS_ARMED:
			begin
				next_count = CNT_RESET;
				if (in_reset)
				begin
					next_state = IRS_RUN;
				end
			end
			IRS_RUN:
			begin
				// measure phase counts, reset phase clears
				if (in_reset || reset_end)
				begin
					next_count = CNT_RESET;
				end
				else if (!wd_expired)
				begin
					next_count = count + CNT_W'(1);
				end
			end
			default:
			begin
				next_state = IRS_LOCKOUT;
				next_count = CNT_RESET;
			end
		endcase
		// lockout whenever supply drops below threshold
		if (!lock_high_s)
		begin
			next_state = IRS_LOCKOUT;
			next_count = CNT_RESET;
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_b)
		begin
			state <= IRS_LOCKOUT;
			count <= CNT_RESET;
			in_reset_prev <= 1'b0;
		end
		else
		begin
			state <= next_state;
			count <= next_count;
			in_reset_prev <= in_reset;
		end
	end

	// single-output variant: second output stays at minimum
	always_ff @(posedge core_clk)
	begin
		if (!rst_b)
		begin
			meas_out <= '0;
			fault_b <= 1'b1;
			calibrating <= 1'b0;
			seq_state <= 2'h0;
		end
		else
		begin
			meas_out.measure_out_a <= measuring && forward;
			meas_out.measure_out_b <= 1'b0;
			meas_out.integ_reset <= (state == IRS_RUN || state == IRS_ARMED) && in_reset;
			if (!lock_high_s || state != IRS_RUN || in_reset)
			begin
				// reset in run or leaving run clears the fault
				fault_b <= 1'b1;
			end
			else if (wd_expired)
			begin
				fault_b <= 1'b0;
			end
			calibrating <= (state == IRS_CALIBRATE);
			seq_state <= state;
		end
	end
endmodule : irs_sequencer

// ===== logic/irs_pkg.sv
// constants and carrier types for the integrator reset sequencer
package irs_pkg;
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned CAL_TIME_NS = 2000;
	localparam int unsigned CAL_CYCLES = (CAL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned WATCHDOG_LIMIT_NS = 100000;
	localparam int unsigned WATCHDOG_LIMIT_CYCLES = WATCHDOG_LIMIT_NS / CLK_PERIOD_NS;
	localparam int unsigned MIN_RESET_NS = 150;
	localparam int unsigned MIN_RESET_CYCLES = (MIN_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned ONESHOT_NS_PER_STEP = 10;
	localparam int unsigned CNT_W = 20;
	localparam logic [CNT_W-1:0] CNT_RESET = 20'h00000;
	localparam logic [11:0] ONESHOT_DEFAULT = 12'h064;

	typedef enum logic [1:0] {
		IRS_LOCKOUT,
		IRS_CALIBRATE,
		IRS_ARMED,
		IRS_RUN
	} irs_state_t;

	typedef struct packed {
		logic [3:0] reset_timing_inputs;
		logic current_entry;
		logic current_exit;
	} irs_link_in_t;

	typedef struct packed {
		logic measure_out_a;
		logic measure_out_b;
		logic integ_reset;
	} irs_meas_out_t;
endpackage : irs_pkg

// ===== logic/irs_sync2.sv
// two flip-flop synchroniser for a bus of pin levels
`timescale 1ns/1ps
module irs_sync2 #(
	parameter int unsigned WIDTH = 1
) (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] stage1;
	always_ff @(posedge core_clk)
	begin
		if (!rst_b)
		begin
			stage1 <= '0;
			sync_out <= '0;
		end
		else
		begin
			stage1 <= async_in;
			sync_out <= stage1;
		end
	end
endmodule : irs_sync2

// ===== logic/irs_oneshot.sv
// programmable one-shot reset stretcher
`timescale 1ns/1ps
module irs_oneshot
	import irs_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic trigger,
	input wire logic [11:0] duration,
	output logic busy
);
	logic [11:0] remain;
	wire logic [11:0] clamped = (duration < 12'(MIN_RESET_CYCLES)) ? 12'(MIN_RESET_CYCLES) : duration;
	wire logic start = trigger && !busy;
	always_ff @(posedge core_clk)
	begin
		if (!rst_b)
		begin
			remain <= 12'h000;
			busy <= 1'b0;
		end
		else if (start)
		begin
			remain <= clamped - 12'h001;
			busy <= 1'b1;
		end
		else if (busy)
		begin
			remain <= remain - 12'h001;
			busy <= (remain != 12'h000);
		end
	end
endmodule : irs_oneshot

// ===== verification/irs_properties.sv
// port assertions for the integrator reset sequencer
`timescale 1ns/1ps
module irs_properties
	import irs_pkg::*;
#(
	parameter int unsigned CAL_LEN = 20,
	parameter int unsigned WD_LEN = 50
) (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic supply_above_lockout_threshold,
	input wire logic supply_above_lockout_hysteresis,
	input wire irs_pkg::irs_link_in_t link_in,
	input wire logic reset_follow_select,
	input wire logic [11:0] oneshot_steps,
	input wire irs_pkg::irs_meas_out_t meas_out,
	input wire logic fault_b,
	input wire logic calibrating,
	input wire logic [1:0] seq_state
);
	localparam int CLO = CAL_LEN - 1;
	localparam int CHI = CAL_LEN + 2;
	localparam int WLO = WD_LEN - 3;
	localparam int WHI = WD_LEN + 4;
	logic [15:0] cnt;
	wire rc = link_in.reset_timing_inputs[0] ^ link_in.reset_timing_inputs[1];
	wire ir = meas_out.integ_reset;
	default clocking dc @(posedge core_clk);
	endclocking
	default disable iff (!rst_b);
	// length of the current reset level, shared by one-shot and watchdog checks
	always_ff @(posedge core_clk)
	begin
		if (!rst_b)
			cnt <= 16'h0000;
		else
			cnt <= $changed(ir) ? 16'h0001 : cnt + 16'h0001;
	end
	property p_lock; $past(seq_state) < 2'h2 && seq_state < 2'h2 |-> meas_out == 3'h0; endproperty
	a_lock: assert property (p_lock) else $error("output active before run");
	property p_exit; $rose(seq_state == 2'h1) |-> $past(supply_above_lockout_hysteresis, 3); endproperty
	a_exit: assert property (p_exit) else $error("left lockout early");
	property p_cal; $rose(seq_state == 2'h1) |-> ##[CLO:CHI] seq_state == 2'h2; endproperty
	a_cal: assert property (p_cal) else $error("calibration length");
	property p_arm; $rose(seq_state == 2'h3) |-> $past(rc, 3); endproperty
	a_arm: assert property (p_arm) else $error("run without reset");
	property p_fol; (reset_follow_select && seq_state == 2'h3 && $stable(rc)) [*6] |-> ir == rc; endproperty
	a_fol: assert property (p_fol) else $error("reset not following");
	property p_rev; (link_in.current_exit && !link_in.current_entry) [*5] |-> !meas_out.measure_out_a; endproperty
	a_rev: assert property (p_rev) else $error("reverse current measured");
	property p_os; $fell(ir) && !reset_follow_select |-> cnt + 16'h2 >= oneshot_steps && cnt <= oneshot_steps + 12'h2; endproperty
	a_os: assert property (p_os) else $error("one-shot length");
	property p_wd; $fell(fault_b) |-> !ir && cnt >= WLO; endproperty
	a_wd: assert property (p_wd) else $error("early fault");
	property p_wdh; seq_state == 2'h3 && !ir && cnt == WHI |-> !fault_b; endproperty
	a_wdh: assert property (p_wdh) else $error("missing fault");
endmodule : irs_properties

// ===== verification/irs_ctl_model.sv
// gate timing source standing in for the converter controller
`timescale 1ns/1ps
module irs_ctl_model
	import irs_pkg::*;
(
	input wire logic core_clk,
	output irs_pkg::irs_link_in_t link_in
);
	initial link_in = '0;
	// levels move only off the sampling edge
	task automatic put(input logic [5:0] v);
		@(negedge core_clk);
		link_in = v;
	endtask : put
endmodule : irs_ctl_model

// ===== verification/tb.sv
// self-checking bench for the integrator reset sequencer
`timescale 1ns/1ps
module tb;
	import irs_pkg::*;
	localparam int unsigned CL = 20;
	localparam int unsigned WL = 50;
	logic core_clk = 1'b0;
	logic rst_b = 1'b0;
	logic supply_above_lockout_threshold = 1'b0;
	logic supply_above_lockout_hysteresis = 1'b0;
	logic reset_follow_select = 1'b1;
	logic [11:0] oneshot_steps = 12'h01e;
	irs_link_in_t link_in;
	irs_meas_out_t meas_out;
	logic fault_b;
	logic calibrating;
	logic [1:0] seq_state;
	int err_count = 0;
	int compares = 0;
	irs_ctl_model i_irs_ctl_model (
		.core_clk(core_clk),
		.link_in(link_in)
	);
	irs_sequencer #(.CAL_LEN(CL), .WD_LEN(WL)) i_irs_sequencer (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.supply_above_lockout_threshold(supply_above_lockout_threshold),
		.supply_above_lockout_hysteresis(supply_above_lockout_hysteresis),
		.link_in(link_in),
		.reset_follow_select(reset_follow_select),
		.oneshot_steps(oneshot_steps),
		.meas_out(meas_out),
		.fault_b(fault_b),
		.calibrating(calibrating),
		.seq_state(seq_state)
	);
	initial
	begin
		forever #5 core_clk = ~core_clk;
	end
	task automatic chk(input string n, input logic [3:0] seen, input logic [3:0] exp);
		compares++;
		if (seen !== exp)
		begin
			err_count++;
			$display("wrong value %s expected %h seen %h", n, exp, seen);
		end
	endtask : chk
	task automatic w(input int n);
		repeat (n) @(negedge core_clk);
	endtask : w
	task automatic summarize();
		if (err_count == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : summarize
	task automatic t_start();
		i_irs_ctl_model.put(6'h06);
		w(6);
		chk("out", meas_out, 4'h0);
		supply_above_lockout_threshold = 1'b1;
		w(8);
		chk("state", seq_state, 4'h0);
		supply_above_lockout_hysteresis = 1'b1;
		w(5);
		chk("cal", calibrating, 4'h1);
		chk("out", meas_out, 4'h0);
		i_irs_ctl_model.put(6'h00);
		w(CL + 4);
		chk("state", seq_state, 4'h2);
	endtask : t_start
	task automatic t_follow();
		i_irs_ctl_model.put(6'h0c);
		w(6);
		chk("state", seq_state, 4'h2);
		i_irs_ctl_model.put(6'h04);
		w(6);
		chk("out", meas_out, 4'h1);
		i_irs_ctl_model.put(6'h02);
		w(6);
		chk("out", meas_out, 4'h4);
		i_irs_ctl_model.put(6'h01);
		w(6);
		chk("out", meas_out, 4'h0);
		i_irs_ctl_model.put(6'h38);
		w(6);
		chk("out", meas_out, 4'h1);
	endtask : t_follow
	task automatic t_oneshot();
		i_irs_ctl_model.put(6'h00);
		w(6);
		reset_follow_select = 1'b0;
		w(4);
		i_irs_ctl_model.put(6'h08);
		w(3);
		i_irs_ctl_model.put(6'h02);
		w(20);
		chk("out", meas_out, 4'h1);
		w(16);
		chk("out", meas_out, 4'h4);
	endtask : t_oneshot
	task automatic t_wd();
		w(WL + 10);
		// fault read as driven level, pull-up external
		chk("fault", fault_b, 4'h0);
		oneshot_steps = 12'h014;
		i_irs_ctl_model.put(6'h04);
		w(6);
		i_irs_ctl_model.put(6'h02);
		w(20);
		chk("out", meas_out, 4'h4);
		w(20);
		chk("fault", fault_b, 4'h1);
		supply_above_lockout_threshold = 1'b0;
		supply_above_lockout_hysteresis = 1'b0;
		w(6);
		chk("out", meas_out, 4'h0);
		supply_above_lockout_threshold = 1'b1;
		supply_above_lockout_hysteresis = 1'b1;
		w(6);
		chk("state", seq_state, 4'h1);
	endtask : t_wd
	initial
	begin
		#20000;
		err_count++;
		summarize();
	end
	initial
	begin
		w(12);
		rst_b = 1'b1;
		t_start();
		t_follow();
		t_oneshot();
		t_wd();
		summarize();
	end
endmodule : tb
bind irs_sequencer irs_properties #(.CAL_LEN(CAL_LEN), .WD_LEN(WD_LEN)) i_irs_properties (
	.core_clk(core_clk),
	.rst_b(rst_b),
	.supply_above_lockout_threshold(supply_above_lockout_threshold),
	.supply_above_lockout_hysteresis(supply_above_lockout_hysteresis),
	.link_in(link_in),
	.reset_follow_select(reset_follow_select),
	.oneshot_steps(oneshot_steps),
	.meas_out(meas_out),
	.fault_b(fault_b),
	.calibrating(calibrating),
	.seq_state(seq_state)
);
